// ==== tas_alarm_top.sv ====
// alarm, standby and one-shot control with its serial register port
`timescale 1ns/1ps
`default_nettype none
module tas_alarm_top
  import tas_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_PERIOD_CYC,
  parameter logic [6:0]  DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // converter
  output logic            conv_start,
  output logic            conv_abort,
  input  wire logic       conv_done,
  input  wire tas_temps_s conv_data,
  input  wire logic       open_cmp,
  // alarm pins
  output logic            shared_pin_n,
  output logic            overtemp_out_n,
  // state
  output logic            standby
);

  // pin synchronisers and edge finding
  logic [1:0] pin_s;
  logic       scl_d_q;
  logic       sda_d_q;

  tas_sync2 #(.W(2)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({scl_in, sda_in}),
    .dout    (pin_s)
  );

  wire scl_s      = pin_s[1];
  wire sda_s      = pin_s[0];
  wire scl_rise   = scl_s & ~scl_d_q;
  wire scl_fall   = ~scl_s & scl_d_q;
  wire start_cond = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_cond  = scl_s & scl_d_q & ~sda_d_q & sda_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // register state
  logic [7:0]      cfg_q;
  logic [7:0]      status_q;
  logic [7:0]      status_d;
  logic [7:0]      hyst_q;
  logic [1:0][7:0] temp_q;
  logic [7:0]      hi_q [NUM_CH];
  logic [7:0]      lo_q [NUM_CH];
  logic [7:0]      th_q [NUM_CH];
  logic [7:0]      st_set;
  logic            alert_q;
  logic            eval_q;

  // serial slave state
  tas_phase_e phase_q, phase_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic       ara_q, ara_d;
  logic       ack_q, ack_d;
  logic       seen_q, seen_d;
  logic       drv_d;
  logic       ara_done_q, ara_done_d;
  tas_wr_s    wr_q, wr_d;

  wire        drv_q     = ~sda_oe_n;
  wire [7:0]  full_byte = {sh_q[6:0], sda_s};
  wire        mask_on   = cfg_q[CFG_MASK_BIT];
  wire        pin_mode  = cfg_q[CFG_PIN_MODE_BIT];
  wire        alert_drv = alert_q & ~mask_on & ~pin_mode; // R09 R17
  wire        addr_dev  = full_byte[7:1] == DEV_ADDR;
  wire        addr_ara  = (full_byte[7:1] == ARA_ADDR) & full_byte[0] & alert_drv; // R20
  wire        in_tx     = phase_q == PH_TX;

  // read selection
  wire [7:0] rd_reg =
    (ptr_q == REG_LOCAL_TEMP)   ? temp_q[0] :
    (ptr_q == REG_REMOTE_TEMP)  ? temp_q[1] :
    (ptr_q == REG_STATUS)       ? status_q  :
    (ptr_q == REG_CONFIG)       ? cfg_q     :
    (ptr_q == REG_HIGH_LIM[0])  ? hi_q[0]   :
    (ptr_q == REG_LOW_LIM[0])   ? lo_q[0]   :
    (ptr_q == REG_HIGH_LIM[1])  ? hi_q[1]   :
    (ptr_q == REG_LOW_LIM[1])   ? lo_q[1]   :
    (ptr_q == REG_OVERTEMP_OUT_N_LIM[0]) ? th_q[0]   :
    (ptr_q == REG_OVERTEMP_OUT_N_LIM[1]) ? th_q[1]   :
    (ptr_q == REG_HYST)         ? hyst_q    : 8'h00;
  wire [7:0] rd_byte = ara_q ? {DEV_ADDR, 1'b1} : rd_reg; // R20

  // serial slave next state; it runs regardless of standby
  always_comb begin // R03
    phase_d    = phase_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    tx_d       = tx_q;
    ptr_d      = ptr_q;
    ara_d      = ara_q;
    ack_d      = ack_q;
    seen_d     = seen_q;
    drv_d      = drv_q;
    wr_d       = '0;
    ara_done_d = 1'b0;
    if (start_cond) begin
      phase_d = PH_ADDR;
      cnt_d   = 4'h0;
      drv_d   = 1'b0;
      seen_d  = 1'b0;
      ack_d   = 1'b0;
      ara_d   = 1'b0;
    end else if (stop_cond) begin
      phase_d = PH_IDLE;
      drv_d   = 1'b0;
    end else if (phase_q != PH_IDLE && scl_rise) begin
      seen_d = 1'b1;
      if (cnt_q == ACK_SLOT) begin
        if (in_tx && sda_s) begin
          phase_d = PH_IDLE;
        end
      end else if (in_tx) begin
        if (tx_q[7] && !sda_s) begin
          // another device with a lower address wins the alert response
          phase_d = PH_IDLE; // R20
          drv_d   = 1'b0;
        end else if (cnt_q == LAST_BIT && ara_q) begin
          ara_done_d = 1'b1; // R11
        end
      end else begin
        sh_d = full_byte;
        if (cnt_q == LAST_BIT) begin
          ack_d = 1'b1;
          case (phase_q)
            PH_ADDR: begin
              if (addr_dev || addr_ara) begin
                ara_d   = addr_ara;
                phase_d = full_byte[0] ? PH_TX : PH_PTR;
              end else begin
                ack_d   = 1'b0;
                phase_d = PH_IDLE;
              end
            end
            PH_PTR: begin
              ptr_d   = full_byte;
              phase_d = PH_WDATA;
            end
            PH_WDATA: begin
              wr_d.stb  = 1'b1;
              wr_d.ptr  = ptr_q;
              wr_d.data = full_byte;
            end
            default: begin
              ack_d = 1'b0;
            end
          endcase
        end
      end
    end else if (phase_q != PH_IDLE && scl_fall && seen_q) begin
      seen_d = 1'b0;
      if (cnt_q == LAST_BIT) begin
        cnt_d = ACK_SLOT;
        drv_d = ack_q;
      end else if (cnt_q == ACK_SLOT) begin
        cnt_d = 4'h0;
        ack_d = 1'b0;
        tx_d  = rd_byte;
        drv_d = in_tx & ~rd_byte[7];
      end else begin
        cnt_d = cnt_q + 4'h1;
        tx_d  = {tx_q[6:0], 1'b0};
        drv_d = in_tx & ~tx_q[6];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q    <= PH_IDLE;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= 8'h00;
      ara_q      <= 1'b0;
      ack_q      <= 1'b0;
      seen_q     <= 1'b0;
      sda_oe_n   <= 1'b1;
      sda_out    <= 1'b0;
      wr_q       <= '0;
      ara_done_q <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      tx_q       <= tx_d;
      ptr_q      <= ptr_d;
      ara_q      <= ara_d;
      ack_q      <= ack_d;
      seen_q     <= seen_d;
      sda_oe_n   <= ~drv_d;
      sda_out    <= 1'b0;
      wr_q       <= wr_d;
      ara_done_q <= ara_done_d;
    end
  end

  // write decode
  wire wr_cfg      = wr_q.stb && wr_q.ptr == REG_CONFIG;
  wire wr_status   = wr_q.stb && wr_q.ptr == REG_STATUS;
  wire wr_hyst     = wr_q.stb && wr_q.ptr == REG_HYST;
  wire wr_one_shot = wr_q.stb && wr_q.ptr == REG_ONE_SHOT; // R05
  logic [NUM_CH-1:0] wr_lim;

  // conversion sequencer
  tas_conv_e   conv_q;
  logic [23:0] timer_q;
  logic        oneshot_pend_q;
  logic        oneshot_q;

  localparam logic [23:0] CONV_LAST = 24'(CONV_CYC - 1);

  wire stby      = cfg_q[CFG_STANDBY_BIT]; // R01
  wire busy      = conv_q == CV_BUSY;
  wire start_go  = !busy && (stby ? oneshot_pend_q : timer_q == CONV_LAST); // R01 R04
  wire abort_now = busy && stby && !oneshot_q; // R02
  wire commit    = busy && !abort_now && conv_done;
  wire open_hit  = start_go && open_cmp; // R07

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_q <= CV_IDLE;
    end else if (start_go) begin
      conv_q <= CV_BUSY;
    end else if (abort_now || commit) begin
      conv_q <= CV_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_q        <= 24'h000000;
      oneshot_pend_q <= 1'b0;
      oneshot_q      <= 1'b0;
      conv_start     <= 1'b0;
      conv_abort     <= 1'b0;
    end else begin
      if (start_go) begin
        timer_q <= 24'h000000;
      end else if (!stby && timer_q != CONV_LAST) begin
        timer_q <= timer_q + 24'h000001;
      end
      oneshot_pend_q <= stby && (wr_one_shot || (oneshot_pend_q && !start_go)); // R04
      if (start_go) begin
        oneshot_q <= stby;
      end
      conv_start <= start_go;
      conv_abort <= abort_now; // R02
    end
  end

  // stored temperatures change only on a finished conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      temp_q <= {TEMP_RST, TEMP_RST};
      eval_q <= 1'b0;
    end else begin
      if (commit) begin
        temp_q <= conv_data; // R02 R04
      end
      eval_q <= commit || (|wr_lim); // R21 R06
    end
  end

  // config and hysteresis
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q  <= CFG_RST;
      hyst_q <= HYST_RST; // R14
    end else begin
      if (wr_cfg) begin
        cfg_q <= wr_q.data & CFG_WR_MASK;
      end
      if (wr_hyst) begin
        hyst_q <= wr_q.data; // R14 R15
      end
    end
  end

  // per channel limits, flags and overtemperature comparators
  logic [NUM_CH-1:0] high_hit;
  logic [NUM_CH-1:0] low_hit;
  logic [NUM_CH-1:0] ot_act;
  logic [NUM_CH-1:0] ot2_act;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire wr_hi = wr_q.stb && wr_q.ptr == REG_HIGH_LIM[i];
    wire wr_lo = wr_q.stb && wr_q.ptr == REG_LOW_LIM[i];
    wire wr_th = wr_q.stb && wr_q.ptr == REG_OVERTEMP_OUT_N_LIM[i];

    assign wr_lim[i]   = wr_hi || wr_lo || wr_th; // R06
    assign high_hit[i] = eval_q && temp_q[i] > hi_q[i]; // R10 R21
    assign low_hit[i]  = eval_q && temp_q[i] <= lo_q[i]; // R10 R21

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        hi_q[i] <= HIGH_LIM_RST;
        lo_q[i] <= LOW_LIM_RST;
        th_q[i] <= OVERTEMP_OUT_N_LIM_RST; // R14
      end else begin
        if (wr_hi) begin
          hi_q[i] <= wr_q.data;
        end
        if (wr_lo) begin
          lo_q[i] <= wr_q.data;
        end
        if (wr_th) begin
          th_q[i] <= wr_q.data;
        end
      end
    end

    tas_overtemp_out_n_chan u_ot (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .temp     (temp_q[i]),
      .limit    (th_q[i]),
      .hyst     (hyst_q),
      .active_q (ot_act[i])
    ); // R19

    tas_overtemp_out_n_chan u_ot2 (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .temp     (temp_q[i]),
      .limit    (hi_q[i]),
      .hyst     (hyst_q),
      .active_q (ot2_act[i])
    ); // R18 R19
  end

  // sticky status, set wins over a write-one clear
  always_comb begin
    st_set                = 8'h00;
    st_set[STAT_OPEN_BIT] = open_hit; // R07
    for (int i = 0; i < NUM_CH; i++) begin
      st_set[STAT_HIGH_BIT[i]] = high_hit[i];
      st_set[STAT_LOW_BIT[i]]  = low_hit[i];
    end
    status_d = (status_q & ~(wr_status ? wr_q.data : 8'h00)) | st_set; // R22
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_d;
    end
  end

  // alarm holds while any flag is set, then waits for an alert response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= (|status_q) || (alert_q && !ara_done_q); // R08 R10 R11
    end
  end

  // output pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shared_pin_n   <= 1'b1;
      overtemp_out_n <= 1'b1;
      standby        <= 1'b0;
    end else begin
      shared_pin_n   <= pin_mode ? ~(|ot2_act) : ~alert_drv; // R09 R17 R18
      overtemp_out_n <= ~(|ot_act); // R09 R12 R19
      standby        <= stby;
    end
  end

endmodule
`default_nettype wire

// ==== tas_pkg.sv ====
// constants and types for the thermal alarm and standby block
// How it works
// R01 - config bit 6 high puts device in standby
// R02 - standby aborts conversion, stored temperatures untouched
// R03 - serial register access keeps working in standby
// R04 - one-shot write in standby converts both channels once
// R05 - one-shot data byte is thrown away
// R06 - limit writes in standby still raise alarm
// R07 - open comparator sampled at conversion start, flag bit 2
// R08 - open flag pulls enabled alarm pin low
// R09 - alarm maskable, overtemperature output never maskable
// R10 - alarm on above high, at/below low, open
// R11 - alarm releases after alert response, clear status
// R12 - overtemp low above its limit, self releasing
// R13 - overtemp releases at limit minus hysteresis
// R14 - overtemp limits reset 85, hysteresis 10, writable
// R15 - hysteresis is plain binary, one degree per bit
// R16 - host keeps overtemp limits at or above high
// R17 - shared pin selects alarm or second overtemp
// R18 - second overtemp uses high limits, same hysteresis
// R19 - each channel drives overtemp outputs on its own
// R20 - alert response answers own address, lowest wins
// R21 - compare after every conversion and limit write
// R22 - status flags sticky until host clears them
package tas_pkg;

  // timing
  localparam int unsigned     CLK_PERIOD_PS   = 4000;
  localparam int unsigned     CONV_PERIOD_US  = 62500;
  localparam longint unsigned CONV_PERIOD_LL  =
    (64'(CONV_PERIOD_US) * 64'd1000000) / 64'(CLK_PERIOD_PS);
  localparam int unsigned     CONV_PERIOD_CYC = int'(CONV_PERIOD_LL);

  // register pointers
  localparam logic [7:0] REG_LOCAL_TEMP  = 8'h00;
  localparam logic [7:0] REG_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] REG_STATUS      = 8'h02;
  localparam logic [7:0] REG_CONFIG      = 8'h03;
  localparam logic [1:0][7:0] REG_HIGH_LIM  = {8'h06, 8'h04};
  localparam logic [1:0][7:0] REG_LOW_LIM   = {8'h07, 8'h05};
  localparam logic [1:0][7:0] REG_OVERTEMP_OUT_N_LIM = {8'h09, 8'h08};
  localparam logic [7:0] REG_HYST        = 8'h0a;
  localparam logic [7:0] REG_ONE_SHOT    = 8'h0f;

  // config and status fields
  localparam int unsigned CFG_MASK_BIT     = 7;
  localparam int unsigned CFG_STANDBY_BIT  = 6;
  localparam int unsigned CFG_PIN_MODE_BIT = 5;
  localparam logic [7:0]  CFG_WR_MASK      = 8'he0;
  localparam int unsigned STAT_OPEN_BIT    = 2;
  localparam logic [1:0][2:0] STAT_HIGH_BIT = {3'h4, 3'h6};
  localparam logic [1:0][2:0] STAT_LOW_BIT  = {3'h3, 3'h5};

  // reset values
  localparam logic [7:0] CFG_RST       = 8'h00;
  localparam logic [7:0] TEMP_RST      = 8'h00;
  localparam logic [7:0] HIGH_LIM_RST  = 8'h46;
  localparam logic [7:0] LOW_LIM_RST   = 8'h00;
  localparam logic [7:0] OVERTEMP_OUT_N_LIM_RST = 8'h55;
  localparam logic [7:0] HYST_RST      = 8'h0a;

  // serial bus
  localparam logic [6:0] ARA_ADDR         = 7'h0c;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a; // arbitrary value
  localparam logic [3:0] LAST_BIT         = 4'h7;
  localparam logic [3:0] ACK_SLOT         = 4'h8;
  localparam int unsigned NUM_CH          = 2;

  typedef struct packed {
    logic [7:0] remote_t;
    logic [7:0] local_t;
  } tas_temps_s;

  typedef struct packed {
    logic       stb;
    logic [7:0] ptr;
    logic [7:0] data;
  } tas_wr_s;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WDATA, PH_TX} tas_phase_e;
  typedef enum logic [1:0] {CV_IDLE, CV_BUSY} tas_conv_e;

endpackage

// ==== tas_sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tas_sync2 #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '1;
      dout   <= '1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== tas_overtemp_out_n_chan.sv ====
// one overtemperature comparator with hysteresis
`timescale 1ns/1ps
`default_nettype none
module tas_overtemp_out_n_chan
  import tas_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // compare inputs
  input  wire logic [7:0] temp,
  input  wire logic [7:0] limit,
  input  wire logic [7:0] hyst,
  // state
  output logic            active_q
);
  wire [7:0] release_at = (limit > hyst) ? 8'(limit - hyst) : 8'h00; // R15
  wire       set_hit    = temp > limit; // R12
  wire       still_hot  = temp > release_at; // R13

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_q ? still_hot : set_hit;
    end
  end
endmodule
`default_nettype wire

// ==== tas_alarm_monitor.sv ====
// concurrent checks on the ports of the alarm and standby block
`timescale 1ns/1ps
`default_nettype none
module tas_alarm_monitor
  import tas_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_PERIOD_CYC,
  parameter logic [6:0]  DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // serial bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // converter
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       conv_done,
  input wire tas_temps_s conv_data,
  input wire logic       open_cmp,
  // alarm pins and state
  input wire logic       shared_pin_n,
  input wire logic       overtemp_out_n,
  input wire logic       standby
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       busy_q;
  logic       scl_q;
  logic [4:0] quiet_q;
  // quiet counts cycles with neither bus clock motion nor a converter start or done
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_q  <= 1'b0;
      scl_q   <= 1'b1;
      quiet_q <= 5'h00;
    end else begin
      busy_q  <= conv_start | (busy_q & ~conv_done & ~conv_abort);
      scl_q   <= scl_in;
      quiet_q <= (conv_done | conv_start | (scl_in != scl_q)) ? 5'h00 :
                 quiet_q + {4'h0, quiet_q != 5'h1f};
    end
  end
  property p_reset_state;
    $past(rst) |-> sda_oe_n && overtemp_out_n && shared_pin_n && !standby && !conv_start;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not idle after reset");
  property p_abort_on_standby;
    $rose(standby) && busy_q |-> ##[0:3] conv_abort;
  endproperty
  a_abort_on_standby: assert property (p_abort_on_standby) else $error("no abort on standby");
  property p_abort_in_standby;
    conv_abort |-> busy_q ##0 (##[0:3] standby);
  endproperty
  a_abort_in_standby: assert property (p_abort_in_standby) else $error("stray abort");
  property p_start_idle;
    conv_start |-> !busy_q ##1 !conv_start;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while converting");
  property p_standby_quiet;
    standby && quiet_q >= 5'd20 |-> !conv_start;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("start in standby");
  property p_overtemp_steady;
    quiet_q >= 5'd20 |-> $stable(overtemp_out_n);
  endproperty
  a_overtemp_steady: assert property (p_overtemp_steady) else $error("overtemp moved");
  property p_pin_steady;
    quiet_q >= 5'd20 |-> $stable(shared_pin_n);
  endproperty
  a_pin_steady: assert property (p_pin_steady) else $error("shared pin moved");
  property p_drive_low;
    $fell(sda_oe_n) |-> !scl_in && !sda_out;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data driven badly");
endmodule
bind tas_alarm_top tas_alarm_monitor #(.CONV_CYC(CONV_CYC), .DEV_ADDR(DEV_ADDR)) i_mon (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .conv_start(conv_start), .conv_abort(conv_abort),
  .conv_done(conv_done), .conv_data(conv_data), .open_cmp(open_cmp),
  .shared_pin_n(shared_pin_n), .overtemp_out_n(overtemp_out_n), .standby(standby));
`default_nettype wire

// ==== tas_host_model.sv ====
// serial bus host model with register and alert response tasks
`timescale 1ns/1ps
`default_nettype none
module tas_host_model
  import tas_pkg::*;
(
  // clock
  input  wire logic ref_clk,
  // bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  int   nak = 0;
  logic a;
  // clock idles high between frames, a released line reads the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic st();
    hc(3);
    sda_drv = 1'b0;
    hc(3);
    scl = 1'b0;
  endtask
  task automatic sp();
    hc(3);
    sda_drv = 1'b0;
    hc(3);
    scl = 1'b1;
    hc(3);
    sda_drv = 1'b1;
    hc(3);
  endtask
  task automatic bx(input logic b, output logic r);
    hc(3);
    sda_drv = b;
    hc(3);
    scl = 1'b1;
    hc(3);
    r = sda;
    hc(3);
    scl = 1'b0;
  endtask
  // eight bits msb first, line released in the ninth slot
  task automatic xb(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bx(d[i], r[i]);
    bx(1'b1, a);
  endtask
  task automatic ck();
    if (a !== 1'b0) nak++;
  endtask
  task automatic pw(input logic [7:0] p);
    logic [7:0] r;
    st();
    xb({DEV_ADDR_DEFAULT, 1'b0}, r);
    ck();
    xb(p, r);
    ck();
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    pw(p);
    xb(d, r);
    ck();
    sp();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    pw(p);
    sp();
    st();
    xb({DEV_ADDR_DEFAULT, 1'b1}, r);
    ck();
    xb(8'hff, d);
    sp();
  endtask
  // c is what the host puts on the line: 8'hff reads, a lower address contends
  task automatic ara(input logic [7:0] c, output logic [7:0] d);
    logic [7:0] r;
    st();
    xb({ARA_ADDR, 1'b1}, r);
    ck();
    xb(c, d);
    sp();
  endtask
endmodule
`default_nettype wire

// ==== test_thermal_alarm_standby_logic.sv ====
// self-checking bench for the alarm, standby and one-shot block
`timescale 1ns/1ps
`default_nettype none
module test_thermal_alarm_standby_logic
  import tas_pkg::*;
;
  logic       ref_clk, rst, conv_done, open_cmp, hold;
  tas_temps_s conv_data;
  wire        scl, sda_drv, sda_w, sda_out, sda_oe_n, conv_start, conv_abort;
  wire        shared_pin_n, overtemp_out_n, standby;
  int         fails = 0, comparisons = 0, cyc = 0, cd = 0, starts = 0, aborts = 0;
  logic [7:0] r;
  assign sda_w = sda_drv & (sda_oe_n | sda_out);
  tas_alarm_top #(.CONV_CYC(50)) i_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_done(conv_done), .conv_data(conv_data),
    .open_cmp(open_cmp), .shared_pin_n(shared_pin_n), .overtemp_out_n(overtemp_out_n),
    .standby(standby));
  tas_host_model i_host (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_drv(sda_drv));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // converter stand-in: done ten cycles after start unless held
  always @(negedge ref_clk) begin
    conv_done <= 1'b0;
    if (conv_start) cd <= 10;
    else if (cd > 0 && !hold) begin
      cd <= cd - 1;
      if (cd == 1) conv_done <= 1'b1;
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (conv_start === 1'b1) starts++;
    if (conv_abort === 1'b1) aborts++;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic setc(input logic [7:0] l, input logic [7:0] rm);
    conv_data = {rm, l};
    wt(150);
  endtask
  task automatic clr();
    i_host.wr(REG_STATUS, 8'hff);
    i_host.ara(8'hff, r);
  endtask
  task automatic t_reset();
    logic [7:0] p[6] = '{8'h08, 8'h09, 8'h0a, 8'h04, 8'h03, 8'h0c};
    logic [7:0] e[6] = '{8'h55, 8'h55, 8'h0a, 8'h46, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      i_host.rd(p[i], r);
      chk("reset value", r, e[i]);
    end
  endtask
  task automatic t_overtemp_out_n();
    i_host.wr(REG_CONFIG, 8'h80);
    setc(8'h56, 8'h30);
    chk("ot local", {7'h0, overtemp_out_n}, 8'h00);
    chk("alarm masked", {7'h0, shared_pin_n}, 8'h01);
    setc(8'h4c, 8'h30);
    chk("ot hyst", {7'h0, overtemp_out_n}, 8'h00);
    setc(8'h4b, 8'h30);
    chk("ot release", {7'h0, overtemp_out_n}, 8'h01);
    setc(8'h30, 8'h56);
    chk("ot remote", {7'h0, overtemp_out_n}, 8'h00);
    i_host.wr(REG_HYST, 8'h01);
    setc(8'h30, 8'h55);
    chk("ot hyst one", {7'h0, overtemp_out_n}, 8'h00);
    setc(8'h30, 8'h54);
    chk("ot hyst one", {7'h0, overtemp_out_n}, 8'h01);
    i_host.wr(REG_HYST, 8'h0a);
    i_host.wr(REG_CONFIG, 8'h00);
    setc(8'h30, 8'h30);
    clr();
  endtask
  task automatic t_alarm();
    logic [7:0] tl[5] = '{8'h47, 8'h30, 8'h30, 8'h20, 8'h30};
    logic [7:0] tr[5] = '{8'h30, 8'h47, 8'h30, 8'h30, 8'h20};
    logic [7:0] ts[5] = '{8'h40, 8'h10, 8'h04, 8'h20, 8'h08};
    i_host.wr(REG_LOW_LIM[0], 8'h20);
    i_host.wr(REG_LOW_LIM[1], 8'h20);
    for (int i = 0; i < 5; i++) begin
      open_cmp = (i == 2);
      setc(tl[i], tr[i]);
      chk("alarm on", {7'h0, shared_pin_n}, 8'h00);
      open_cmp = 1'b0;
      setc(8'h30, 8'h30);
      i_host.rd(REG_STATUS, r);
      chk("status", r, ts[i]);
      i_host.wr(REG_STATUS, 8'hff);
      wt(20);
      chk("alarm held", {7'h0, shared_pin_n}, 8'h00);
      if (i == 0) begin
        // host pulls a lower address onto the line, the device must drop out
        i_host.ara(8'h31, r);
        chk("ara lost", r, 8'h31);
        chk("alarm kept", {7'h0, shared_pin_n}, 8'h00);
      end
      i_host.ara(8'hff, r);
      chk("ara addr", r, {DEV_ADDR_DEFAULT, 1'b1});
      chk("alarm off", {7'h0, shared_pin_n}, 8'h01);
    end
    i_host.wr(REG_LOW_LIM[0], 8'h00);
    i_host.wr(REG_LOW_LIM[1], 8'h00);
  endtask
  task automatic t_pin();
    // overtemp limits stay at 0x55, above the 0x46 high limits
    i_host.wr(REG_CONFIG, 8'ha0);
    setc(8'h47, 8'h30);
    chk("pin ot2", {7'h0, shared_pin_n}, 8'h00);
    setc(8'h3d, 8'h30);
    chk("pin ot2 hyst", {7'h0, shared_pin_n}, 8'h00);
    setc(8'h3c, 8'h30);
    chk("pin ot2 off", {7'h0, shared_pin_n}, 8'h01);
    setc(8'h30, 8'h47);
    chk("pin ot2 rem", {7'h0, shared_pin_n}, 8'h00);
    setc(8'h30, 8'h30);
    i_host.wr(REG_CONFIG, 8'h00);
    clr();
  endtask
  task automatic t_standby();
    int s0;
    hold = 1'b1;
    wt(60);
    i_host.wr(REG_CONFIG, 8'h40);
    chk("standby", {7'h0, standby}, 8'h01);
    chk("aborted", {7'h0, aborts != 0}, 8'h01);
    conv_data = {8'h41, 8'h40};
    hold = 1'b0;
    s0 = starts;
    wt(200);
    chk("no starts", 8'(starts - s0), 8'h00);
    i_host.rd(REG_LOCAL_TEMP, r);
    chk("temp kept", r, 8'h30);
    s0 = starts;
    i_host.wr(REG_ONE_SHOT, 8'ha5);
    wt(100);
    chk("one shot", 8'(starts - s0), 8'h01);
    chk("back standby", {7'h0, standby}, 8'h01);
    i_host.rd(REG_REMOTE_TEMP, r);
    chk("shot remote", r, 8'h41);
    i_host.wr(REG_HIGH_LIM[0], 8'h3f);
    wt(20);
    chk("standby alarm", {7'h0, shared_pin_n}, 8'h00);
    i_host.wr(REG_HIGH_LIM[0], 8'h46);
    chk("bus acks", 8'(i_host.nak), 8'h00);
  endtask
  initial begin
    rst = 1'b1;
    open_cmp = 1'b0;
    hold = 1'b0;
    conv_data = {8'h30, 8'h30};
    wt(8);
    rst = 1'b0;
    wt(4);
    fork
      begin
        t_reset();
        t_overtemp_out_n();
        t_alarm();
        t_pin();
        t_standby();
      end
      wait (cyc >= 90000);
    join_any
    if (cyc >= 90000) fails++;
    stop_test();
  end
endmodule
`default_nettype wire
